/* File: gpio_pkg.sv */
package gpio_pkg;

    // ******************************************
    // Bus geometry
    // ******************************************
    localparam int          ADDR_W      = 12;
    localparam int          DATA_W      = 32;
    localparam int          REG_W       = 8;
    localparam int          SHARED_W    = 10;
    localparam int          SHARED_LO_W = 2;

    // ******************************************
    // Register indices, byte address is index times four
    // ******************************************
    localparam logic [9:0]  IDX_J_DATA       = 10'h266;
    localparam logic [9:0]  IDX_J_DIR        = 10'h268;
    localparam logic [9:0]  IDX_J_DRIVE      = 10'h269;
    localparam logic [9:0]  IDX_J_PULL       = 10'h26A;
    localparam logic [9:0]  IDX_J_POLARITY   = 10'h26B;
    localparam logic [9:0]  IDX_J_IRQ_EN     = 10'h26C;
    localparam logic [9:0]  IDX_J_IRQ_FLAG   = 10'h26D;
    localparam logic [9:0]  IDX_SH_DATA_LO   = 10'h270;
    localparam logic [9:0]  IDX_SH_DATA_HI   = 10'h271;
    localparam logic [9:0]  IDX_SH_DIR_LO    = 10'h272;
    localparam logic [9:0]  IDX_SH_DIR_HI    = 10'h273;
    localparam logic [9:0]  IDX_SH_ANALOG_LO = 10'h274;
    localparam logic [9:0]  IDX_SH_ANALOG_HI = 10'h275;

    // ******************************************
    // Field layout and reset values
    // ******************************************
    localparam logic [7:0]  J_IMPL_MASK  = 8'hC7;
    localparam logic [7:0]  REG_RST      = 8'h00;
    localparam logic [9:0]  SHARED_RST   = 10'h000;
    localparam logic [31:0] RDATA_RST    = 32'h0000_0000;
    localparam logic [23:0] RDATA_PAD    = 24'h00_0000;
    localparam logic [5:0]  SH_LO_PAD    = 6'h00;

    // ******************************************
    // Pin carriers
    // ******************************************
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
        logic [7:0] reduced_drive;
        logic [7:0] pull_enable;
        logic [7:0] pull_down;
    } first_port_pins_t;

    typedef struct packed {
        logic [9:0] out;
        logic [9:0] oe;
    } shared_port_pins_t;

endpackage

/* File: edge_irq_gpio_port.sv */
`timescale 1ns/1ps

// Functional notes
// - First port direction bit one makes the pin output, zero input.
// - Drive select picks reduced or full drive, only for output pins.
// - Pull enable acts only while the pin is an input.
// - Polarity one gives pull-down and rising edge, zero pull-up and falling.
// - Interrupt enable zero masks the flag from requesting an interrupt.
// - An edge of selected polarity on a pin sets its interrupt flag.
// - Writing one clears an interrupt flag, writing zero leaves it.
// - Interrupt request is high while any flag and its enable are set.
// - Shared data read returns register bit if output, else buffered pin.
// - Shared data register bits are driven onto pins in output mode.
// - Shared pins are general purpose only while not used as analog inputs.
// - First port interrupts work whether the pin is input or output.
module edge_irq_gpio_port
    import gpio_pkg::*;
(
    // Clock and reset
    input  wire logic                mclk,
    input  wire logic                sys_rst,
    // Avalon-MM slave
    input  wire logic [ADDR_W-1:0]   avs_address,
    input  wire logic                avs_read,
    input  wire logic                avs_write,
    input  wire logic [DATA_W-1:0]   avs_writedata,
    input  wire logic [3:0]          avs_byteenable,
    output logic      [DATA_W-1:0]   avs_readdata,
    output logic                     avs_waitrequest,
    // Interrupt
    output logic                     irq,
    // First port pins
    input  wire logic [REG_W-1:0]    first_port_in,
    output first_port_pins_t         first_port_pins,
    // Shared port pins
    input  wire logic [SHARED_W-1:0] shared_port_in,
    output shared_port_pins_t        shared_port_pins
);

    // ******************************************
    // Registers
    // ******************************************
    logic [REG_W-1:0]    j_data_r;
    logic [REG_W-1:0]    first_port_direction_r;
    logic [REG_W-1:0]    first_port_drive_select_r;
    logic [REG_W-1:0]    first_port_pull_enable_r;
    logic [REG_W-1:0]    first_port_polarity_select_r;
    logic [REG_W-1:0]    first_port_irq_enable_r;
    logic [REG_W-1:0]    first_port_irq_flag_r;
    logic [SHARED_W-1:0] shared_data_r;
    logic [SHARED_W-1:0] shared_dir_r;
    logic [SHARED_W-1:0] shared_analog_r;
    logic [REG_W-1:0]    j_meta_r;
    logic [REG_W-1:0]    j_sync_r;
    logic [REG_W-1:0]    j_prev_r;
    logic [SHARED_W-1:0] sh_meta_r;
    logic [SHARED_W-1:0] sh_sync_r;
    logic                wait_r;
    logic [DATA_W-1:0]   rdata_r;
    logic                irq_r;
    first_port_pins_t    j_pins_r;
    shared_port_pins_t   sh_pins_r;

    logic [REG_W-1:0]    edge_hit;
    logic [REG_W-1:0]    irq_flag_nxt;
    logic [REG_W-1:0]    rd_val;
    logic [SHARED_W-1:0] sh_read;
    logic [9:0]          idx;
    logic                wr_acc;
    logic                wr_lane;
    logic [REG_W-1:0]    wr_byte;

    // ******************************************
    // Bus handshake
    // ******************************************
    // One wait state: the read mux is registered, so answers take two edges
    assign idx     = avs_address[ADDR_W-1:2];
    assign wr_acc  = avs_write && !wait_r;
    assign wr_lane = wr_acc && avs_byteenable[0];
    assign wr_byte = avs_writedata[REG_W-1:0];

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
            wait_r <= 1'b1;
        else if ((avs_read || avs_write) && wait_r)
            wait_r <= 1'b0;
        else
            wait_r <= 1'b1;
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
            rdata_r <= RDATA_RST;
        else if (avs_read && wait_r)
            rdata_r <= {RDATA_PAD, rd_val};
    end

    assign avs_waitrequest = wait_r;
    assign avs_readdata    = rdata_r;

    // ******************************************
    // Read mux
    // ******************************************
    // Direction selects register or pin image per bit
    assign sh_read = (shared_dir_r & shared_data_r) | (~shared_dir_r & sh_sync_r);

    always_comb
    begin
        rd_val = REG_RST;
        case (idx)
            IDX_J_DATA:
                rd_val = ((first_port_direction_r & j_data_r)
                         | (~first_port_direction_r & j_sync_r)) & J_IMPL_MASK;
            IDX_J_DIR:        rd_val = first_port_direction_r;
            IDX_J_DRIVE:      rd_val = first_port_drive_select_r;
            IDX_J_PULL:       rd_val = first_port_pull_enable_r;
            IDX_J_POLARITY:   rd_val = first_port_polarity_select_r;
            IDX_J_IRQ_EN:     rd_val = first_port_irq_enable_r;
            IDX_J_IRQ_FLAG:   rd_val = first_port_irq_flag_r;
            IDX_SH_DATA_LO:   rd_val = {SH_LO_PAD, sh_read[SHARED_LO_W-1:0]};
            IDX_SH_DATA_HI:   rd_val = sh_read[SHARED_W-1:SHARED_LO_W];
            IDX_SH_DIR_LO:    rd_val = {SH_LO_PAD, shared_dir_r[SHARED_LO_W-1:0]};
            IDX_SH_DIR_HI:    rd_val = shared_dir_r[SHARED_W-1:SHARED_LO_W];
            IDX_SH_ANALOG_LO: rd_val = {SH_LO_PAD, shared_analog_r[SHARED_LO_W-1:0]};
            IDX_SH_ANALOG_HI: rd_val = shared_analog_r[SHARED_W-1:SHARED_LO_W];
            default:          rd_val = REG_RST;
        endcase
    end

    // ******************************************
    // First port configuration
    // ******************************************
    // Mask keeps unimplemented bits at zero for good
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            j_data_r                     <= REG_RST;
            first_port_direction_r       <= REG_RST;
            first_port_drive_select_r    <= REG_RST;
            first_port_pull_enable_r     <= REG_RST;
            first_port_polarity_select_r <= REG_RST;
            first_port_irq_enable_r      <= REG_RST;
        end
        else if (wr_lane)
        begin
            case (idx)
                IDX_J_DATA:     j_data_r <= wr_byte & J_IMPL_MASK;
                IDX_J_DIR:      first_port_direction_r <= wr_byte & J_IMPL_MASK;
                IDX_J_DRIVE:    first_port_drive_select_r <= wr_byte & J_IMPL_MASK;
                IDX_J_PULL:     first_port_pull_enable_r <= wr_byte & J_IMPL_MASK;
                IDX_J_POLARITY: first_port_polarity_select_r <= wr_byte & J_IMPL_MASK;
                IDX_J_IRQ_EN:   first_port_irq_enable_r <= wr_byte & J_IMPL_MASK;
                default:        j_data_r <= j_data_r;
            endcase
        end
    end

    // ******************************************
    // Shared port registers
    // ******************************************
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            shared_data_r   <= SHARED_RST;
            shared_dir_r    <= SHARED_RST;
            shared_analog_r <= SHARED_RST;
        end
        else if (wr_lane)
        begin
            case (idx)
                IDX_SH_DATA_LO:
                    shared_data_r[SHARED_LO_W-1:0] <= avs_writedata[SHARED_LO_W-1:0];
                IDX_SH_DATA_HI:
                    shared_data_r[SHARED_W-1:SHARED_LO_W] <= wr_byte;
                IDX_SH_DIR_LO:
                    shared_dir_r[SHARED_LO_W-1:0] <= avs_writedata[SHARED_LO_W-1:0];
                IDX_SH_DIR_HI:
                    shared_dir_r[SHARED_W-1:SHARED_LO_W] <= wr_byte;
                IDX_SH_ANALOG_LO:
                    shared_analog_r[SHARED_LO_W-1:0] <= avs_writedata[SHARED_LO_W-1:0];
                IDX_SH_ANALOG_HI:
                    shared_analog_r[SHARED_W-1:SHARED_LO_W] <= wr_byte;
                default:
                    shared_data_r <= shared_data_r;
            endcase
        end
    end

    // ******************************************
    // Input synchronisers
    // ******************************************
    // Pins may toggle freely, so two stages before any logic looks at them
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            j_meta_r  <= REG_RST;
            j_sync_r  <= REG_RST;
            j_prev_r  <= REG_RST;
            sh_meta_r <= SHARED_RST;
            sh_sync_r <= SHARED_RST;
        end
        else
        begin
            j_meta_r  <= first_port_in;
            j_sync_r  <= j_meta_r;
            j_prev_r  <= j_sync_r;
            sh_meta_r <= shared_port_in;
            sh_sync_r <= sh_meta_r;
        end
    end

    // ******************************************
    // Edge detect and flags
    // ******************************************
    // Pin image is used whatever the direction, so outputs interrupt too
    genvar b;
    generate
        for (b = 0; b < REG_W; b++)
        begin : g_edge
            assign edge_hit[b] = J_IMPL_MASK[b] &&
                (first_port_polarity_select_r[b] ? (j_sync_r[b] && !j_prev_r[b])
                                                 : (!j_sync_r[b] && j_prev_r[b]));
            // Set wins over a same-cycle clear
            assign irq_flag_nxt[b] = edge_hit[b] ||
                (first_port_irq_flag_r[b] &&
                 !(wr_lane && idx == IDX_J_IRQ_FLAG && avs_writedata[b]));
        end
    endgenerate

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
            first_port_irq_flag_r <= REG_RST;
        else
            first_port_irq_flag_r <= irq_flag_nxt;
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
            irq_r <= 1'b0;
        else
            irq_r <= |(irq_flag_nxt & first_port_irq_enable_r);
    end

    assign irq = irq_r;

    // ******************************************
    // Pin drivers
    // ******************************************
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            j_pins_r  <= '0;
            sh_pins_r <= '0;
        end
        else
        begin
            j_pins_r.out           <= j_data_r;
            j_pins_r.oe            <= first_port_direction_r;
            j_pins_r.reduced_drive <= first_port_drive_select_r & first_port_direction_r;
            j_pins_r.pull_enable   <= first_port_pull_enable_r & ~first_port_direction_r;
            j_pins_r.pull_down     <= first_port_polarity_select_r;
            sh_pins_r.out          <= shared_data_r;
            sh_pins_r.oe           <= shared_dir_r & ~shared_analog_r;
        end
    end

    assign first_port_pins  = j_pins_r;
    assign shared_port_pins = sh_pins_r;

    // ******************************************
    // Assertions
    // ******************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    dir_to_oe_a: assert property (##1 j_pins_r.oe == $past(first_port_direction_r))
        else $error("first port enable does not follow direction");
    drive_gate_a: assert property (##1 (j_pins_r.reduced_drive & ~j_pins_r.oe) == REG_RST)
        else $error("reduced drive on input pin");
    pull_gate_a: assert property (##1 (j_pins_r.pull_enable & j_pins_r.oe) == REG_RST)
        else $error("pull device on output pin");
    rise_sets_a: assert property ((first_port_polarity_select_r[0] && j_sync_r[0] && !j_prev_r[0])
        |=> first_port_irq_flag_r[0])
        else $error("rising edge missed");
    fall_sets_a: assert property ((!first_port_polarity_select_r[1] && !j_sync_r[1] && j_prev_r[1])
        |=> first_port_irq_flag_r[1])
        else $error("falling edge missed");
    no_edge_a: assert property ((edge_hit == REG_RST && !wr_lane)
        |=> first_port_irq_flag_r == $past(first_port_irq_flag_r))
        else $error("flag changed without cause");
    w1c_clear_a: assert property ((wr_lane && idx == IDX_J_IRQ_FLAG && avs_writedata[1] && !edge_hit[1])
        |=> !first_port_irq_flag_r[1])
        else $error("write one did not clear flag");
    irq_level_a: assert property (##1 irq_r == |($past(irq_flag_nxt) & $past(first_port_irq_enable_r)))
        else $error("interrupt level wrong");
    masked_quiet_a: assert property ((first_port_irq_enable_r == REG_RST)[*2] |-> !irq_r)
        else $error("masked flag raised interrupt");
    impl_mask_a: assert property ((first_port_irq_flag_r & ~J_IMPL_MASK) == REG_RST)
        else $error("unimplemented bit set");
    analog_off_a: assert property (##1 (sh_pins_r.oe & $past(shared_analog_r)) == SHARED_RST)
        else $error("analog pin driven");
    sh_out_a: assert property (##1 sh_pins_r.out == $past(shared_data_r))
        else $error("shared output wrong");
    wait_one_a: assert property ((avs_read || avs_write) && wait_r |=> !wait_r ##1 wait_r)
        else $error("waitrequest not one cycle");

    // Pin fields lag their registers by one cycle, hence the past values
    pull_sel_a: assert property (
        ##1 j_pins_r.pull_down == $past(first_port_polarity_select_r))
        else $error("pull device select does not follow polarity");
    pull_in_a: assert property (
        ##1 j_pins_r.pull_enable == $past(first_port_pull_enable_r & ~first_port_direction_r))
        else $error("pull enable not gated by direction");
    cfg_mask_a: assert property (
        ((j_data_r | first_port_direction_r | first_port_drive_select_r
          | first_port_pull_enable_r | first_port_polarity_select_r
          | first_port_irq_enable_r) & ~J_IMPL_MASK) == REG_RST)
        else $error("unimplemented configuration bit set");
    out_edge_a: assert property (
        (first_port_direction_r[7] && first_port_polarity_select_r[7]
         && j_sync_r[7] && !j_prev_r[7]) |=> first_port_irq_flag_r[7])
        else $error("output pin edge missed");
    // Reads are checked one edge after the request is taken
    sh_reg_read_a: assert property (
        (avs_read && wait_r && idx == IDX_SH_DATA_HI && &shared_dir_r[SHARED_W-1:SHARED_LO_W])
        |=> rdata_r[REG_W-1:0] == $past(shared_data_r[SHARED_W-1:SHARED_LO_W]))
        else $error("shared read did not return register");
    sh_pin_read_a: assert property (
        (avs_read && wait_r && idx == IDX_SH_DATA_HI && shared_dir_r == SHARED_RST)
        |=> rdata_r[REG_W-1:0] == $past(sh_sync_r[SHARED_W-1:SHARED_LO_W]))
        else $error("shared read did not return pin");
    rdata_pad_a: assert property (rdata_r[DATA_W-1:REG_W] == RDATA_PAD)
        else $error("read data upper bits not zero");

    edge_irq_c: cover property (edge_hit[0] ##1 irq_r);
    clear_c:    cover property (first_port_irq_flag_r[6] ##1 !first_port_irq_flag_r[6]);
    read_c:     cover property (avs_read && !wait_r);
    analog_c:   cover property (shared_dir_r[9] && shared_analog_r[9]);
    out_flag_c: cover property (first_port_direction_r[7] && edge_hit[7]);

endmodule // edge_irq_gpio_port

/* File: pin_board_model.sv */
`timescale 1ns/1ps

module pin_board_model
    import gpio_pkg::*;
(
    // Device side
    input  wire first_port_pins_t  first_port_pins,
    input  wire shared_port_pins_t shared_port_pins,
    // Board stimulus
    input  wire logic [7:0]        board_j,
    input  wire logic [7:0]        board_j_en,
    input  wire logic [9:0]        board_sh,
    // Resolved pin levels
    output logic      [7:0]        first_port_in,
    output logic      [9:0]        shared_port_in
);

    // ******************************************
    // Pin resolution
    // ******************************************
    // Undriven pin without pull shows the inverse, never a stale level
    always_comb
    begin
        first_port_in = (first_port_pins.oe & first_port_pins.out)
                      | (~first_port_pins.oe & board_j_en & board_j)
                      | (~first_port_pins.oe & ~board_j_en & first_port_pins.pull_enable
                         & ~first_port_pins.pull_down)
                      | (~first_port_pins.oe & ~board_j_en & ~first_port_pins.pull_enable
                         & ~board_j);
        shared_port_in = (shared_port_pins.oe & shared_port_pins.out)
                       | (~shared_port_pins.oe & board_sh);
    end

endmodule // pin_board_model

/* File: test_edge_irq_gpio_port.sv */
`timescale 1ns/1ps

module test_edge_irq_gpio_port;
    import gpio_pkg::*;

    logic                    mclk;
    logic                    sys_rst;
    logic [ADDR_W-1:0]       avs_address;
    logic                    avs_read;
    logic                    avs_write;
    logic [DATA_W-1:0]       avs_writedata;
    logic [3:0]              avs_byteenable;
    logic [DATA_W-1:0]       avs_readdata;
    logic                    avs_waitrequest;
    logic                    irq;
    logic [REG_W-1:0]        first_port_in;
    first_port_pins_t        first_port_pins;
    logic [SHARED_W-1:0]     shared_port_in;
    shared_port_pins_t       shared_port_pins;
    logic [7:0]              board_j;
    logic [7:0]              board_j_en;
    logic [9:0]              board_sh;
    logic [7:0]              v;
    int                      fails;
    int                      cmp_count;
    int                      cycles;
    logic [9:0]              rst_idx [11];

    edge_irq_gpio_port u_edge_irq_gpio_port (.mclk(mclk), .sys_rst(sys_rst),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
        .first_port_in(first_port_in), .first_port_pins(first_port_pins),
        .shared_port_in(shared_port_in), .shared_port_pins(shared_port_pins));

    pin_board_model u_pin_board_model (.first_port_pins(first_port_pins),
        .shared_port_pins(shared_port_pins), .board_j(board_j), .board_j_en(board_j_en),
        .board_sh(board_sh), .first_port_in(first_port_in),
        .shared_port_in(shared_port_in));

    // ******************************************
    // Clock and timeout
    // ******************************************
    initial
    begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    // Whole run needs well under a thousand cycles
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            fails++;
            give_verdict();
        end
    end

    // ******************************************
    // Bus and check tasks
    // ******************************************
    task automatic wr(input logic [9:0] idx, input logic [7:0] d);
        @(posedge mclk);
        avs_address   <= {idx, 2'b00};
        avs_writedata <= {RDATA_PAD, d};
        avs_write     <= 1'b1;
        do @(posedge mclk); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
    endtask

    task automatic rd(input logic [9:0] idx, output logic [7:0] d);
        @(posedge mclk);
        avs_address <= {idx, 2'b00};
        avs_read    <= 1'b1;
        do @(posedge mclk); while (avs_waitrequest !== 1'b0);
        d = avs_readdata[7:0];
        avs_read <= 1'b0;
    endtask

    task automatic check(input string name, input logic [9:0] seen, input logic [9:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            fails++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // ******************************************
    // Main sequence
    // ******************************************
    initial
    begin
        rst_idx = '{IDX_J_DIR, IDX_J_DRIVE, IDX_J_PULL, IDX_J_POLARITY, IDX_J_IRQ_EN,
                    IDX_J_IRQ_FLAG, IDX_SH_DIR_LO, IDX_SH_DIR_HI, IDX_SH_ANALOG_LO,
                    IDX_SH_ANALOG_HI, 10'h100};
        sys_rst = 1'b1;
        avs_address = '0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = '0;
        avs_byteenable = 4'hF;
        board_j = 8'h02;
        board_j_en = 8'hFF;
        board_sh = 10'h2B6;
        repeat (6) @(posedge mclk);
        sys_rst <= 1'b0;
        foreach (rst_idx[i])
        begin
            rd(rst_idx[i], v);
            check("reset value", v, 10'h000);
        end
        // Pin controls
        wr(IDX_J_DIR, 8'hFF);
        rd(IDX_J_DIR, v);
        check("dir readback", v, 10'h0C7);
        wr(IDX_J_DRIVE, 8'hFF);
        wr(IDX_J_PULL, 8'hFF);
        wr(IDX_J_POLARITY, 8'hFF);
        settle(2);
        check("oe", first_port_pins.oe, 10'h0C7);
        check("drive", first_port_pins.reduced_drive, 10'h0C7);
        check("pull out", first_port_pins.pull_enable, 10'h000);
        check("pull down", first_port_pins.pull_down, 10'h0C7);
        wr(IDX_J_DIR, 8'h01);
        settle(2);
        check("drive in", first_port_pins.reduced_drive, 10'h001);
        check("pull in", first_port_pins.pull_enable, 10'h0C6);
        avs_byteenable <= 4'h0;
        wr(IDX_J_DIR, 8'hFF);
        avs_byteenable <= 4'hF;
        rd(IDX_J_DIR, v);
        check("byte lane off", v, 10'h001);
        // Edge interrupts
        wr(IDX_J_DIR, 8'h00);
        wr(IDX_J_PULL, 8'h00);
        wr(IDX_J_POLARITY, 8'h01);
        settle(8);
        wr(IDX_J_IRQ_FLAG, 8'hFF);
        board_j <= 8'h11;
        settle(8);
        rd(IDX_J_IRQ_FLAG, v);
        check("flags", v, 10'h003);
        check("irq masked", irq, 10'h000);
        board_j <= 8'h02;
        settle(8);
        rd(IDX_J_IRQ_FLAG, v);
        check("wrong edges", v, 10'h003);
        wr(IDX_J_IRQ_EN, 8'h01);
        settle(2);
        check("irq on", irq, 10'h001);
        wr(IDX_J_IRQ_FLAG, 8'h02);
        rd(IDX_J_IRQ_FLAG, v);
        check("clear one", v, 10'h001);
        wr(IDX_J_IRQ_FLAG, 8'h01);
        settle(2);
        check("irq off", irq, 10'h000);
        // Output pin still raises its flag
        wr(IDX_J_POLARITY, 8'h80);
        wr(IDX_J_IRQ_EN, 8'h80);
        wr(IDX_J_DIR, 8'h80);
        wr(IDX_J_DATA, 8'h80);
        settle(8);
        rd(IDX_J_IRQ_FLAG, v);
        check("out flag", v, 10'h080);
        check("out irq", irq, 10'h001);
        rd(IDX_J_DATA, v);
        check("j data", v, 10'h082);
        // Shared port
        wr(IDX_SH_DIR_LO, 8'h03);
        wr(IDX_SH_DIR_HI, 8'hFF);
        wr(IDX_SH_DATA_LO, 8'h02);
        wr(IDX_SH_DATA_HI, 8'hA5);
        settle(2);
        check("sh out", shared_port_pins.out, 10'h296);
        check("sh oe", shared_port_pins.oe, 10'h3FF);
        rd(IDX_SH_DATA_HI, v);
        check("sh reg", v, 10'h0A5);
        wr(IDX_SH_ANALOG_HI, 8'hF0);
        settle(2);
        check("sh analog", shared_port_pins.oe, 10'h03F);
        wr(IDX_SH_DIR_LO, 8'h00);
        wr(IDX_SH_DIR_HI, 8'h00);
        settle(8);
        rd(IDX_SH_DATA_LO, v);
        check("sh pin lo", v, 10'h002);
        rd(IDX_SH_DATA_HI, v);
        check("sh pin hi", v, 10'h0AD);
        // Released pins fall back to their pull devices
        wr(IDX_J_PULL, 8'hFF);
        settle(2);
        board_j_en <= 8'h00;
        settle(8);
        rd(IDX_J_DATA, v);
        check("pull up", v, 10'h0C7);
        wr(IDX_J_POLARITY, 8'hFF);
        settle(8);
        rd(IDX_J_DATA, v);
        check("pull down pins", v, 10'h080);
        rd(IDX_J_IRQ_FLAG, v);
        check("no pull edge", v, 10'h080);
        give_verdict();
    end

endmodule // test_edge_irq_gpio_port
